// File: design/timer_b_pkg.sv
// Package: register map, field layout and types of the two-channel capture/compare timer
package timer_b_pkg;
  localparam logic [7:0] REG_MAIN_CTRL = 8'h00;
  localparam logic [7:0] REG_CNT_HI = 8'h04;
  localparam logic [7:0] REG_CNT_LO = 8'h08;
  localparam logic [7:0] REG_PER_HI = 8'h0C;
  localparam logic [7:0] REG_PER_LO = 8'h10;
  localparam logic [7:0] REG_CH0_CTRL = 8'h14;
  localparam logic [7:0] REG_CH0_HI = 8'h18;
  localparam logic [7:0] REG_CH0_LO = 8'h1C;
  localparam logic [7:0] REG_CH1_CTRL = 8'h20;
  localparam logic [7:0] REG_CH1_HI = 8'h24;
  localparam logic [7:0] REG_CH1_LO = 8'h28;
  localparam logic [7:0] REG_PIN_STATUS = 8'h2C;
  // Main control bit positions
  localparam int MC_FLAG = 7;
  localparam int MC_IE = 6;
  localparam int MC_HALT = 5;
  localparam int MC_CLR = 4;
  localparam int MC_PS_LSB = 0;
  // Channel control bit positions
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_MSB = 5;
  localparam int CC_MSA = 4;
  localparam int CC_ELB = 3;
  localparam int CC_ELA = 2;
  localparam int CC_TOV = 1;
  localparam int CC_MAX = 0;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [2:0] PS_INVALID = 3'h7;
  localparam logic [1:0] EL_OFF = 2'h0;
  localparam logic [1:0] EL_RISE = 2'h1;
  localparam logic [1:0] EL_FALL = 2'h2;
  localparam logic [1:0] EL_ANY = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    MODE_PRESET = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10
  } ch_mode_e;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buffered_mode_sel;
    logic direction_mode_sel;
    logic [1:0] edge_level_sel;
    logic overflow_toggle_en;
    logic full_duty_force;
    logic max_active;
    logic out_level;
    logic flag_armed;
    logic [15:0] value;
    logic [7:0] cap_lo_latch;
    logic hi_read_lock;
    logic hi_write_lock;
    logic [7:0] wr_hi_pend;
    logic pin_prev;
  } channel_s;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } ahb_req_s;
endpackage

// File: design/timer_b.sv
// Two-channel 16-bit capture/compare/PWM timer with AHB-Lite register slave
//
// Contract
// (RQ1) Halt plus clear in one write stops counter at zero.
// (RQ2) Prescaler codes 0..6 divide bus clock by 1..64; reset clears.
// (RQ3) High count read latches low byte until low byte read.
// (RQ4) Count registers read-only; cleared by reset and counter clear.
// (RQ5) Count equal to period sets overflow flag; next tick restarts at zero.
// (RQ6) Period high write suppresses overflow until low byte written.
// (RQ7) Reset sets period registers to all ones.
// (RQ8) Channel flag set on capture edge or compare match.
// (RQ9) Flag clear needs read while set then write 0; new event wins.
// (RQ10) Channel irq enable gates channel interrupt; reset clears.
// (RQ11) Buffered mode bit only in channel 0; reset clears.
// (RQ12) Direction bit picks capture/compare, or initial level when edge field 00.
// (RQ13) Software halts and clears counter before changing mode bits.
// (RQ14) Edge field 00 leaves pin to port, presets output state.
// (RQ15) Capture edges: rising 01, falling 10, either 11.
// (RQ16) Compare action: toggle 01, clear 10, set 11.
// (RQ17) Overflow toggle bit toggles compare output each overflow.
// (RQ18) Overflow action beats simultaneous compare action.
// (RQ19) Full-duty force gives 100 percent from next period.
// (RQ20) Channel value holds capture or compare value; reset undefined.
// (RQ21) Capture: value high read blocks captures until low read.
// (RQ22) Compare: value high write blocks matches until low written.
// (RQ23) Halt bit freezes counting; reset sets it.
// (RQ24) Counter clear zeroes counter and prescaler; self-clears, reads 0.
// (RQ25) Buffered mode links channels 0 and 1; channel 0 values first.
// (RQ26) 16-bit counter increments on each prescaled tick when running.
`timescale 1ns/1ps
module timer_b
  import timer_b_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_CH-1:0] channel_pin_in,
  output logic [NUM_CH-1:0] channel_pin_out,
  output logic [NUM_CH-1:0] channel_pin_oe,
  output logic overflow_irq,
  output logic [NUM_CH-1:0] channel_irq
);

  typedef struct packed {
    ahb_req_s req;
    logic [31:0] rdata;
    logic counter_halt;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic ovf_armed;
    logic [2:0] prescale_sel;
    logic [5:0] prescaler;
    logic [15:0] count;
    logic [15:0] period;
    logic period_hi_lock;
    logic [7:0] period_hi_pend;
    logic [7:0] count_lo_latch;
    logic count_lo_held;
    logic buf_active_ch1;
    channel_s [NUM_CH-1:0] ch;
    logic [NUM_CH-1:0] pin_out;
    logic [NUM_CH-1:0] pin_oe;
    logic ovf_irq;
    logic [NUM_CH-1:0] ch_irq;
  } state_s;

  state_s st;
  state_s next_st;
  logic rst_meta;
  logic rst_sync_n;

  // Tick when the low prescaler bits selected by the code are all ones
  function automatic logic prescale_tick(input logic [2:0] sel, input logic [5:0] pre);
    logic [5:0] mask;
    mask = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (i < int'(sel))
      begin
        mask[i] = 1'b1;
      end
    end
    return (pre & mask) == mask;
  endfunction

  // Decode a channel's mode from its select bits
  function automatic ch_mode_e chan_mode(input channel_s c);
    if (c.edge_level_sel == EL_OFF)
    begin
      return MODE_PRESET;
    end
    else if (c.buffered_mode_sel || c.direction_mode_sel)
    begin
      return MODE_COMPARE;
    end
    return MODE_CAPTURE;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Outputs come straight from the state register; zero-wait slave, always OKAY
  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign channel_pin_out = st.pin_out;
  assign channel_pin_oe = st.pin_oe;
  assign overflow_irq = st.ovf_irq;
  assign channel_irq = st.ch_irq;

  // State register; reset branch holds constants only
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st <= '0;
      st.counter_halt <= 1'b1; // RQ23
      st.period <= PERIOD_RESET; // RQ7
    end
    else
    begin
      st <= next_st;
    end
  end

  // All state advances here
  always_comb
  begin
    logic tick;
    logic ovf;
    logic wr;
    logic rd;
    logic [7:0] wd;
    logic [7:0] a;
    logic [7:0] ctl;
    ch_mode_e m;
    logic match;
    logic edge_hit;
    logic pin_now;
    logic src_ch1;
    logic [15:0] cmp_val;
    logic [NUM_CH-1:0] ev;
    tick = 1'b0;
    ovf = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wd = 8'h00;
    a = 8'h00;
    ctl = 8'h00;
    m = MODE_PRESET;
    match = 1'b0;
    edge_hit = 1'b0;
    pin_now = 1'b0;
    src_ch1 = 1'b0;
    cmp_val = COUNT_ZERO;
    ev = '0;
    next_st = st;

    // Bus: address phase captured, data phase acts next cycle with zero wait
    next_st.req.sel = hsel && hready && (htrans == HTRANS_NONSEQ);
    next_st.req.write = hwrite;
    next_st.req.addr = haddr[7:0];
    wr = st.req.sel && st.req.write;
    rd = st.req.sel && !st.req.write;
    wd = hwdata[7:0];
    a = st.req.addr;

    // Prescaler and counter
    tick = !st.counter_halt && prescale_tick(st.prescale_sel, st.prescaler);
    ovf = tick && (st.count == st.period); // RQ5
    if (!st.counter_halt)
    begin
      next_st.prescaler = st.prescaler + 6'h01;
    end
    if (tick) // RQ23
    begin
      next_st.count = ovf ? COUNT_ZERO : st.count + 16'h0001; // RQ26 RQ5
    end
    if (ovf && !st.period_hi_lock) // RQ6
    begin
      next_st.overflow_flag = 1'b1;
    end

    // Buffered pair flips its active value register each period
    if (ovf && st.ch[0].buffered_mode_sel)
    begin
      next_st.buf_active_ch1 = !st.buf_active_ch1; // RQ25
    end
    next_st.ovf_irq = st.overflow_flag && st.overflow_irq_enable;

    for (int c = 0; c < NUM_CH; c++)
    begin
      m = chan_mode(st.ch[c]);
      pin_now = channel_pin_in[c];
      next_st.ch[c].pin_prev = pin_now;
      if (m == MODE_PRESET)
      begin
        next_st.ch[c].out_level = !st.ch[c].direction_mode_sel; // RQ12 RQ14
        next_st.pin_oe[c] = 1'b0; // RQ14
      end
      else if (m == MODE_CAPTURE)
      begin
        next_st.pin_oe[c] = 1'b0;
        unique case (st.ch[c].edge_level_sel) // RQ15
          EL_RISE: edge_hit = pin_now && !st.ch[c].pin_prev;
          EL_FALL: edge_hit = !pin_now && st.ch[c].pin_prev;
          EL_ANY: edge_hit = pin_now != st.ch[c].pin_prev;
          default: edge_hit = 1'b0;
        endcase
        if (edge_hit && !st.counter_halt && !st.ch[c].hi_read_lock) // RQ21
        begin
          next_st.ch[c].value = st.count; // RQ20
          next_st.ch[c].flag = 1'b1; // RQ8
          ev[c] = 1'b1;
        end
      end
      else
      begin
        // Compare; when buffered, channel 1 releases its pin and channel 0 alternates between both value registers
        next_st.pin_oe[c] = !(c == 1 && st.ch[0].buffered_mode_sel);
        src_ch1 = (c == 0) && st.ch[0].buffered_mode_sel && st.buf_active_ch1;
        cmp_val = src_ch1 ? st.ch[1].value : st.ch[c].value;
        match = tick && (st.count == cmp_val) && !st.ch[c].hi_write_lock; // RQ22
        if (ovf)
        begin
          next_st.ch[c].max_active = st.ch[c].full_duty_force; // RQ19
        end
        if (match)
        begin
          next_st.ch[c].flag = 1'b1; // RQ8
          ev[c] = 1'b1;
        end
        if (ovf && st.ch[c].overflow_toggle_en) // RQ17 RQ18
        begin
          next_st.ch[c].out_level = st.ch[c].max_active ? st.ch[c].out_level
                                                        : !st.ch[c].out_level;
          if (st.ch[c].full_duty_force && !st.ch[c].max_active)
          begin
            next_st.ch[c].out_level = !st.ch[c].out_level;
          end
        end
        else if (match && !(st.ch[c].overflow_toggle_en && st.ch[c].max_active))
        begin
          unique case (st.ch[c].edge_level_sel) // RQ16
            EL_RISE: next_st.ch[c].out_level = !st.ch[c].out_level;
            EL_FALL: next_st.ch[c].out_level = 1'b0;
            EL_ANY: next_st.ch[c].out_level = 1'b1;
            default: next_st.ch[c].out_level = st.ch[c].out_level;
          endcase
        end
      end
      next_st.pin_out[c] = next_st.ch[c].out_level;
      next_st.ch_irq[c] = st.ch[c].flag && st.ch[c].irq_en; // RQ10
    end

    // Register reads and their side effects
    next_st.rdata = 32'h0000_0000;
    if (next_st.req.sel && !hwrite)
    begin
      case (haddr[7:0])
        REG_MAIN_CTRL: next_st.rdata[7:0] = {st.overflow_flag, st.overflow_irq_enable,
                                             st.counter_halt, 1'b0, 1'b0, st.prescale_sel};
        REG_CNT_HI: next_st.rdata[7:0] = st.count[15:8];
        REG_CNT_LO: next_st.rdata[7:0] = st.count_lo_held ? st.count_lo_latch
                                                          : st.count[7:0]; // RQ3
        REG_PER_HI: next_st.rdata[7:0] = st.period[15:8];
        REG_PER_LO: next_st.rdata[7:0] = st.period[7:0];
        REG_CH0_CTRL, REG_CH1_CTRL:
        begin
          ctl = 8'h00;
          for (int c = 0; c < NUM_CH; c++)
          begin
            if (haddr[7:0] == (c == 0 ? REG_CH0_CTRL : REG_CH1_CTRL))
            begin
              ctl = {st.ch[c].flag, st.ch[c].irq_en, st.ch[c].buffered_mode_sel,
                     st.ch[c].direction_mode_sel, st.ch[c].edge_level_sel,
                     st.ch[c].overflow_toggle_en, st.ch[c].full_duty_force};
            end
          end
          next_st.rdata[7:0] = ctl;
        end
        REG_CH0_HI: next_st.rdata[7:0] = st.ch[0].value[15:8];
        REG_CH0_LO: next_st.rdata[7:0] = st.ch[0].hi_read_lock ? st.ch[0].cap_lo_latch
                                                               : st.ch[0].value[7:0];
        REG_CH1_HI: next_st.rdata[7:0] = st.ch[1].value[15:8];
        REG_CH1_LO: next_st.rdata[7:0] = st.ch[1].hi_read_lock ? st.ch[1].cap_lo_latch
                                                               : st.ch[1].value[7:0];
        REG_PIN_STATUS: next_st.rdata[7:0] = {6'h00, st.pin_out};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (rd)
    begin
      case (a)
        REG_MAIN_CTRL: next_st.ovf_armed = st.overflow_flag;
        REG_CNT_HI:
        begin
          if (!st.count_lo_held) // RQ3
          begin
            next_st.count_lo_latch = st.count[7:0];
            next_st.count_lo_held = 1'b1;
          end
        end
        REG_CNT_LO: next_st.count_lo_held = 1'b0; // RQ3
        REG_CH0_CTRL: next_st.ch[0].flag_armed = st.ch[0].flag; // RQ9
        REG_CH1_CTRL: next_st.ch[1].flag_armed = st.ch[1].flag; // RQ9
        REG_CH0_HI, REG_CH1_HI:
        begin
          for (int c = 0; c < NUM_CH; c++)
          begin
            if (a == (c == 0 ? REG_CH0_HI : REG_CH1_HI) && chan_mode(st.ch[c]) == MODE_CAPTURE)
            begin
              next_st.ch[c].hi_read_lock = 1'b1; // RQ21
              next_st.ch[c].cap_lo_latch = st.ch[c].value[7:0];
            end
          end
        end
        REG_CH0_LO: next_st.ch[0].hi_read_lock = 1'b0;
        REG_CH1_LO: next_st.ch[1].hi_read_lock = 1'b0;
        default: ;
      endcase
    end

    // Register writes
    if (wr)
    begin
      case (a)
        REG_MAIN_CTRL:
        begin
          next_st.overflow_irq_enable = wd[MC_IE];
          next_st.counter_halt = wd[MC_HALT]; // RQ23
          next_st.prescale_sel = wd[MC_PS_LSB +: 3]; // RQ2
          if (!wd[MC_FLAG] && st.ovf_armed && !(ovf && !st.period_hi_lock))
          begin
            next_st.overflow_flag = 1'b0;
          end
          next_st.ovf_armed = 1'b0;
          if (wd[MC_CLR]) // RQ24 RQ1 RQ4
          begin
            next_st.count = COUNT_ZERO;
            next_st.prescaler = 6'h00;
          end
        end
        REG_PER_HI:
        begin
          next_st.period_hi_pend = wd;
          next_st.period_hi_lock = 1'b1; // RQ6
        end
        REG_PER_LO:
        begin
          next_st.period = {st.period_hi_lock ? st.period_hi_pend : st.period[15:8], wd};
          next_st.period_hi_lock = 1'b0;
        end
        default:
        begin
          for (int c = 0; c < NUM_CH; c++)
          begin
            if (a == (c == 0 ? REG_CH0_CTRL : REG_CH1_CTRL))
            begin
              next_st.ch[c].irq_en = wd[CC_IE]; // RQ10
              next_st.ch[c].buffered_mode_sel = (c == 0) ? wd[CC_MSB] : 1'b0; // RQ11
              next_st.ch[c].direction_mode_sel = wd[CC_MSA]; // RQ12
              next_st.ch[c].edge_level_sel = {wd[CC_ELB], wd[CC_ELA]};
              next_st.ch[c].overflow_toggle_en = wd[CC_TOV];
              next_st.ch[c].full_duty_force = wd[CC_MAX];
              // A fresh event in the clearing cycle keeps the flag
              if (!wd[CC_FLAG] && st.ch[c].flag_armed && !ev[c]) // RQ9
              begin
                next_st.ch[c].flag = 1'b0;
              end
              next_st.ch[c].flag_armed = 1'b0;
            end
            if (a == (c == 0 ? REG_CH0_HI : REG_CH1_HI))
            begin
              next_st.ch[c].wr_hi_pend = wd;
              next_st.ch[c].hi_write_lock = chan_mode(st.ch[c]) == MODE_COMPARE; // RQ22
            end
            if (a == (c == 0 ? REG_CH0_LO : REG_CH1_LO))
            begin
              next_st.ch[c].value = {st.ch[c].wr_hi_pend, wd}; // RQ20
              next_st.ch[c].hi_write_lock = 1'b0;
            end
          end
        end
      endcase
    end
  end
endmodule

// File: verification/timer_b_monitor.sv
// Port-level checker for the two-channel timer and its bus slave
`timescale 1ns/1ps
module timer_b_monitor
  import timer_b_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_CH-1:0] channel_pin_oe,
  input wire logic [NUM_CH-1:0] channel_irq
);
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic cnt_zero;
  logic per_fresh;
  logic done;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Data phase completes on the edge that sees ready high
  assign done = dp_valid && hready;

  // Shadow of the data phase; cnt_zero tracks a counter known to sit at zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      cnt_zero <= 1'b1;
      per_fresh <= 1'b1;
    end
    else
    begin
      if (hready)
      begin
        dp_valid <= hsel && htrans == HTRANS_NONSEQ;
        dp_write <= hwrite;
        dp_addr <= haddr[7:0];
      end
      if (done && dp_write && dp_addr == REG_MAIN_CTRL && !hwdata[MC_HALT])
        cnt_zero <= 1'b0;
      else if (done && dp_write && dp_addr == REG_MAIN_CTRL && hwdata[MC_CLR])
        cnt_zero <= 1'b1;
      if (done && dp_write && (dp_addr == REG_PER_HI || dp_addr == REG_PER_LO))
        per_fresh <= 1'b0;
    end
  end

  sequence s_read(logic [7:0] a);
    done && !dp_write && dp_addr == a;
  endsequence
  sequence s_write(logic [7:0] a);
    done && dp_write && dp_addr == a;
  endsequence

  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("slave gave a non-okay response");
  property p_ready_bounded;
    hsel && htrans == HTRANS_NONSEQ && hready |=> ##[0:15] hreadyout;
  endproperty
  a_ready_bounded: assert property (p_ready_bounded) else $error("data phase never completed");
  property p_clear_reads_zero;
    s_read(REG_MAIN_CTRL) |-> !hrdata[MC_CLR];
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read as one");
  property p_ch1_no_buffered;
    s_read(REG_CH1_CTRL) |-> !hrdata[CC_MSB];
  endproperty
  a_ch1_no_buffered: assert property (p_ch1_no_buffered) else $error("buffered bit on channel 1");
  property p_period_reset;
    s_read(REG_PER_HI) ##0 per_fresh |-> hrdata[7:0] == 8'hFF;
  endproperty
  a_period_reset: assert property (p_period_reset) else $error("period not all ones after reset");
  property p_count_zero;
    done && !dp_write && (dp_addr == REG_CNT_HI || dp_addr == REG_CNT_LO) && cnt_zero
      |-> hrdata[7:0] == 8'h00;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("stopped counter not at zero");
  property p_irq_gate;
    s_write(REG_CH0_CTRL) ##0 !hwdata[CC_IE] |-> ##2 !channel_irq[0] [*2];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("channel irq with enable clear");
  property p_port_control;
    s_write(REG_CH0_CTRL) ##0 hwdata[CC_ELB:CC_ELA] == EL_OFF |-> ##2 !channel_pin_oe[0];
  endproperty
  a_port_control: assert property (p_port_control) else $error("pin driven in preset mode");
endmodule

bind timer_b timer_b_monitor #(.NUM_CH(NUM_CH)) mon_u (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .channel_pin_oe(channel_pin_oe),
  .channel_irq(channel_irq)
);

// File: verification/test_timer_b.sv
// Self-checking bench for the two-channel timer over its bus slave
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch %s exp %0h got %0h", what, exp, got); \
    end \
  end
module test_timer_b;
  import timer_b_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] pin_in = 2'h0;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic ovf_irq;
  logic [1:0] ch_irq;
  logic [15:0] cnt;
  logic [15:0] snap;
  logic [7:0] hi8;
  logic [7:0] lo8;
  logic [1:0] el;
  int bad_count = 0;
  int n_compared = 0;

  always #12.5 clk_sys = ~clk_sys;

  // Bus ready loops back from the only slave
  timer_b #(.NUM_CH(2)) dut_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .channel_pin_in(pin_in),
    .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe),
    .overflow_irq(ovf_irq),
    .channel_irq(ch_irq)
  );

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One single transfer; each phase held until ready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] wd,
                      output logic [7:0] r);
    int i;
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    for (int ph = 0; ph < 2; ph++)
    begin
      i = 0;
      do
      begin
        @(posedge clk_sys);
        i++;
      end
      while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50)
      begin
        bad_count++;
        $display("mismatch hready wait exp 1 got 0");
        results();
      end
      if (ph == 0)
      begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
      end
    end
    r = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(a, 1'b0, 8'h00, r);
    `CHK($sformatf("reg %0h", a), e, r)
  endtask

  // High byte first, so the low byte comes from the latch
  task automatic rd_count(output logic [15:0] c);
    logic [7:0] h;
    logic [7:0] l;
    xfer(REG_CNT_HI, 1'b0, 8'h00, h);
    xfer(REG_CNT_LO, 1'b0, 8'h00, l);
    c = {h, l};
  endtask

  // Let the counter run for a while, then halt it again
  task automatic run_for(input logic [7:0] mc, input int n);
    wr(REG_MAIN_CTRL, mc);
    repeat (n) @(posedge clk_sys);
    wr(REG_MAIN_CTRL, 8'hA0);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Reset state and read-only places
    chk_rd(REG_MAIN_CTRL, 8'h20);
    chk_rd(REG_PER_HI, 8'hFF);
    chk_rd(REG_PER_LO, 8'hFF);
    chk_rd(REG_CH0_CTRL, 8'h00);
    wr(REG_CNT_HI, 8'hAB);
    chk_rd(REG_CNT_HI, 8'h00);
    chk_rd(REG_CNT_LO, 8'h00);
    wr(REG_CH1_CTRL, 8'h20);
    chk_rd(REG_CH1_CTRL, 8'h00);
    wr(REG_CH0_CTRL, 8'h20);
    chk_rd(REG_CH0_CTRL, 8'h20);
    wr(REG_CH0_CTRL, 8'h00);
    // Overflow at a short period, then a half-written period holds it off
    wr(REG_MAIN_CTRL, 8'h30);
    wr(REG_PER_HI, 8'h00);
    wr(REG_PER_LO, 8'h08);
    run_for(8'h00, 40);
    chk_rd(REG_MAIN_CTRL, 8'hA0);
    rd_count(cnt);
    `CHK("count within period", 1'b1, cnt <= 16'h0008)
    wr(REG_MAIN_CTRL, 8'h30);
    chk_rd(REG_MAIN_CTRL, 8'h20);
    rd_count(cnt);
    `CHK("count after halt and clear", 16'h0000, cnt)
    wr(REG_PER_HI, 8'h00);
    run_for(8'h00, 40);
    chk_rd(REG_MAIN_CTRL, 8'h20);
    wr(REG_MAIN_CTRL, 8'h30);
    wr(REG_PER_LO, 8'h08);
    run_for(8'h00, 40);
    chk_rd(REG_MAIN_CTRL, 8'hA0);
    // Prescaler codes 0 to 6 over a fixed run; slack covers the bus overhead
    wr(REG_PER_HI, 8'hFF);
    wr(REG_PER_LO, 8'hFF);
    for (int k = 0; k < 7; k++)
    begin
      wr(REG_MAIN_CTRL, 8'h30);
      run_for(8'(k), 128);
      rd_count(cnt);
      `CHK("prescaled count", 1'b1, cnt >= (16'd128 >> k) && cnt <= (16'd128 >> k) + 16'd6)
    end
    repeat (20) @(posedge clk_sys);
    rd_count(snap);
    `CHK("halted count", cnt, snap)
    // Latched low byte keeps the older value while the counter runs on
    wr(REG_MAIN_CTRL, 8'h30);
    wr(REG_MAIN_CTRL, 8'h00);
    xfer(REG_CNT_HI, 1'b0, 8'h00, hi8);
    repeat (30) @(posedge clk_sys);
    xfer(REG_CNT_LO, 1'b0, 8'h00, lo8);
    wr(REG_MAIN_CTRL, 8'h20);
    rd_count(cnt);
    snap = cnt - {hi8, lo8};
    `CHK("latched low byte age", 1'b1, snap >= 16'd30 && snap <= 16'd60)
    // Compare on channel 0: preset low, then set, clear and toggle
    wr(REG_CH0_HI, 8'h00);
    wr(REG_CH0_LO, 8'h05);
    wr(REG_CH0_CTRL, 8'h10);
    repeat (2) @(posedge clk_sys);
    `CHK("preset pin enable", 1'b0, pin_oe[0])
    for (int k = 0; k < 3; k++)
    begin
      el = 2'(3 - k);
      wr(REG_MAIN_CTRL, 8'h30);
      wr(REG_CH0_CTRL, {4'h5, el, 2'b00});
      run_for(8'h00, 30);
      `CHK("compare output", k != 1, pin_out[0])
      `CHK("channel irq", 1'b1, ch_irq[0])
      chk_rd(REG_CH0_CTRL, {4'hD, el, 2'b00});
      wr(REG_CH0_CTRL, {4'h5, el, 2'b00});
      chk_rd(REG_CH0_CTRL, {4'h5, el, 2'b00});
    end
    `CHK("compare pin enable", 1'b1, pin_oe[0])
    // Capture on channel 1 for each edge code, both edges each time
    for (int k = 1; k < 4; k++)
    begin
      el = 2'(k);
      wr(REG_MAIN_CTRL, 8'h30);
      wr(REG_CH1_CTRL, {4'h0, el, 2'b00});
      wr(REG_MAIN_CTRL, 8'h00);
      pin_in[1] <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_rd(REG_CH1_CTRL, {el[0], 3'h0, el, 2'b00});
      wr(REG_CH1_CTRL, {4'h0, el, 2'b00});
      pin_in[1] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk_rd(REG_CH1_CTRL, {el[1], 3'h0, el, 2'b00});
      wr(REG_CH1_CTRL, {4'h0, el, 2'b00});
    end
    results();
  end
endmodule
